/* File: design/sio_line_drv.sv */
// One line's output selector: an enabled peripheral wins over the port latch.
// Assumes the control side has already resolved steering per line.
`timescale 1ns/10ps
`default_nettype none
module sio_line_drv #(parameter int IDX = 0) (
	sio_ovr_if.drv bus // Drive requests for all lines
);
	// Peripheral takes the pad; the latch path only when nothing else is enabled
	assign bus.pad_dat[IDX] = bus.ovr_en[IDX] ? bus.ovr_dat[IDX] : bus.gp_dat[IDX];
	assign bus.pad_oe[IDX] = bus.ovr_en[IDX] ? bus.ovr_oe[IDX] : bus.gp_oe[IDX];
endmodule
`default_nettype wire

/* File: design/sio_port.sv */
// Six-line I/O port: direction, latch and analog-select registers, live pin
// reads and steering of the serial module's functions between line pairs.
// Assumes pads resolve level from pad_out_o/pad_oe_o and return it on pad_in_i.
`timescale 1ns/10ps
`default_nettype none
module sio_port #(parameter int N = 6) (
	input wire logic sys_clk_i,                          // 250 MHz system clock
	input wire logic sys_rst_i,                          // Async reset, active high
	input wire logic [sio_pkg::SIO_ADDR_W-1:0] reg_addr_i, // Register index
	input wire logic [7:0] reg_wdata_i,                  // Write data
	input wire logic reg_wr_i,                           // Write strobe
	input wire logic reg_rd_i,                           // Read strobe
	output logic [7:0] reg_rdata_o,                      // Read data, cycle after strobe
	input wire logic [N-1:0] pad_in_i,                   // Pin levels
	output logic [N-1:0] pad_out_o,                      // Pin drive level
	output logic [N-1:0] pad_oe_o,                       // Pin driver enable
	output logic [N-1:0] ana_sel_o,                      // Analog mode, buffer off
	input wire logic ser_out_en_i,                       // Serial data-out enabled
	input wire logic serial_data_out_i,                  // Serial data-out level
	input wire logic ser_sda_low_i,                      // Serial pulls data line low
	output logic serial_data_in_o,                       // Steered data-in level
	output logic ser_ss_n_o                              // Steered slave select, low
);
	import sio_pkg::*;

	logic [N-1:0] dir_ff;
	logic [N-1:0] lat_ff;
	logic [N-1:0] ana_ff;
	logic [2:0] steer_ff;
	logic [N-1:0] nxt_dir;
	logic [N-1:0] nxt_lat;
	logic [N-1:0] nxt_ana;
	logic [2:0] nxt_steer;
	logic [7:0] nxt_rdata;
	logic nxt_sdi;
	logic nxt_ss_n;
	logic [N-1:0] pin_sync;
	wire logic [N-1:0] pin_lvl;
	wire logic wr_pin, wr_dir, wr_lat, wr_ana, wr_steer, wr_set, wr_clr;
	wire logic sdo_line4, sda_line3;
	wire logic [7:0] rd_mux;

	sio_ovr_if #(.N(N)) ovr ();

	// Pin levels pass two flops before any read or peripheral sees them
	sio_sync #(.W(N)) u_sync (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i(pad_in_i),
		.q_o(pin_sync)
	);

	// Analog lines have the input buffer off, so they read as zero
	assign pin_lvl = pin_sync & ~ana_ff;

	// Register write decode
	assign wr_pin = reg_wr_i && (reg_addr_i == SIO_OFF_PIN);
	assign wr_dir = reg_wr_i && (reg_addr_i == SIO_OFF_DIR);
	assign wr_lat = reg_wr_i && (reg_addr_i == SIO_OFF_LAT);
	assign wr_ana = reg_wr_i && (reg_addr_i == SIO_OFF_ANA);
	assign wr_steer = reg_wr_i && (reg_addr_i == SIO_OFF_STEER);
	assign wr_set = reg_wr_i && (reg_addr_i == SIO_OFF_PIN_SET);
	assign wr_clr = reg_wr_i && (reg_addr_i == SIO_OFF_PIN_CLR);

	// Latch update: plain writes through either port or latch address, and
	// bit-modify writes that merge sampled pin levels with the data byte.
	// An analog line samples as zero here, so a modify can clear its latch.
	always_comb begin
		nxt_lat = lat_ff;
		if (wr_pin || wr_lat) begin
			nxt_lat = reg_wdata_i[N-1:0] & SIO_IMPL_MASK;
		end else if (wr_set) begin
			nxt_lat = (pin_lvl | reg_wdata_i[N-1:0]) & SIO_IMPL_MASK;
		end else if (wr_clr) begin
			nxt_lat = (pin_lvl & ~reg_wdata_i[N-1:0]) & SIO_IMPL_MASK;
		end
	end

	// Direction, analog and steering updates; steering never touches direction
	assign nxt_dir = wr_dir ? (reg_wdata_i[N-1:0] | SIO_LINE3_MASK) : dir_ff;
	assign nxt_ana = wr_ana ? (reg_wdata_i[N-1:0] & SIO_IMPL_MASK) : ana_ff;
	assign nxt_steer = wr_steer ? reg_wdata_i[SIO_SDO_BIT:SIO_STEER_LSB] : steer_ff;

	// Register state
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dir_ff <= SIO_DIR_RST;
			lat_ff <= SIO_LAT_RST;
			ana_ff <= SIO_ANA_RST;
			steer_ff <= SIO_STEER_RST;
		end else begin
			dir_ff <= nxt_dir;
			lat_ff <= nxt_lat;
			ana_ff <= nxt_ana;
			steer_ff <= nxt_steer;
		end
	end

	// Read mux: live levels on the port address, stored values on the direction, latch, analog and steering addresses, zero elsewhere
	assign rd_mux = (reg_addr_i == SIO_OFF_PIN) ? {2'h0, pin_lvl} :
		(reg_addr_i == SIO_OFF_DIR) ? {2'h0, dir_ff | SIO_LINE3_MASK} :
		(reg_addr_i == SIO_OFF_LAT) ? {2'h0, lat_ff} :
		(reg_addr_i == SIO_OFF_ANA) ? {2'h0, ana_ff} :
		(reg_addr_i == SIO_OFF_STEER) ? {1'h0, steer_ff, 4'h0} :
		8'h00;
	assign nxt_rdata = reg_rd_i ? rd_mux : 8'h00;

	// Steering of the serial functions onto lines
	assign sdo_line4 = steer_ff[SIO_SDO_BIT - SIO_STEER_LSB];
	assign sda_line3 = steer_ff[SIO_SDI_BIT - SIO_STEER_LSB];

	// Only the selected line of each pair gets the override; the other keeps
	// ordinary port behaviour. Line 3 can only be pulled low by the serial
	// module, never driven from the latch.
	assign ovr.gp_dat = lat_ff;
	assign ovr.gp_oe = ~dir_ff & SIO_IMPL_MASK;
	assign ovr.ovr_en = {1'h0,
		ser_out_en_i & sdo_line4,
		ser_sda_low_i & sda_line3,
		ser_sda_low_i & ~sda_line3,
		1'h0,
		ser_out_en_i & ~sdo_line4};
	assign ovr.ovr_dat = {1'h0, serial_data_out_i, 3'h0, serial_data_out_i};
	assign ovr.ovr_oe = {N{1'h1}};

	// One priority cell per line
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_line
			sio_line_drv #(.IDX(gi)) u_drv (
				.bus(ovr.drv)
			);
		end
	endgenerate

	// Serial inputs follow the selected line of each pair
	assign nxt_sdi = sda_line3 ? pin_lvl[3] : pin_lvl[2];
	assign nxt_ss_n = steer_ff[SIO_SS_BIT - SIO_STEER_LSB] ? pin_lvl[0] : pin_lvl[3];

	// Every output leaves through a flop; pads lag register state by one cycle
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 8'h00;
			pad_out_o <= '0;
			pad_oe_o <= '0;
			ana_sel_o <= SIO_ANA_RST;
			serial_data_in_o <= 1'h0;
			ser_ss_n_o <= SIO_SS_RST;
		end else begin
			reg_rdata_o <= nxt_rdata;
			pad_out_o <= ovr.pad_dat;
			pad_oe_o <= ovr.pad_oe;
			ana_sel_o <= ana_ff;
			serial_data_in_o <= nxt_sdi;
			ser_ss_n_o <= nxt_ss_n;
		end
	end

	// Checks on the port behaviour
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	// Input line never drives without a peripheral on it
	chk_dir_input_off: assert property (
		dir_ff[1] && dir_ff[5] |=> !pad_oe_o[1] && !pad_oe_o[5]
	) else $error("input line driver enabled");

	// Output line drives the latch value, analog or not
	chk_dir_output_on: assert property (
		!dir_ff[5] |=> pad_oe_o[5] && (pad_out_o[5] == $past(lat_ff[5]))
	) else $error("output line not driving latch");

	chk_analog_drive: assert property (
		!dir_ff[1] && ana_ff[1] |=> pad_oe_o[1] && (pad_out_o[1] == $past(lat_ff[1]))
	) else $error("analog select disturbed output");

	// Line 3 drives only when the serial module pulls it low
	chk_line3_only_low: assert property (
		pad_oe_o[3] |-> !pad_out_o[3] && $past(ser_sda_low_i) && $past(sda_line3)
	) else $error("line 3 driven without pull-low");

	chk_line3_dir_read: assert property (
		reg_rd_i && (reg_addr_i == SIO_OFF_DIR) |=> reg_rdata_o[3] && reg_rdata_o[7:6] == 2'h0
	) else $error("line 3 direction not read as one");

	// Port read returns live levels masked by analog select
	chk_pin_read: assert property (
		reg_rd_i && (reg_addr_i == SIO_OFF_PIN) |=>
			reg_rdata_o == {2'h0, $past(pin_sync) & ~$past(ana_ff)}
	) else $error("pin read mismatch");

	chk_analog_zero: assert property (
		reg_rd_i && (reg_addr_i == SIO_OFF_PIN) && ana_ff[0] |=> !reg_rdata_o[0]
	) else $error("analog line read as one");

	chk_lat_read: assert property (
		reg_rd_i && (reg_addr_i == SIO_OFF_LAT) |=> reg_rdata_o == {2'h0, $past(lat_ff)}
	) else $error("latch read mismatch");

	// Read data holds for one cycle only
	chk_rdata_one: assert property (
		!reg_rd_i |=> reg_rdata_o == 8'h00
	) else $error("read data outside its cycle");

	// Writing the port address lands in the latch
	chk_pin_write: assert property (
		wr_pin |=> lat_ff == ($past(reg_wdata_i[N-1:0]) & SIO_IMPL_MASK)
	) else $error("port write missed latch");

	// Bit-modify writes merge sampled levels
	chk_rmw_set: assert property (
		wr_set |=> lat_ff == (($past(pin_lvl) | $past(reg_wdata_i[N-1:0])) & SIO_IMPL_MASK)
	) else $error("bit-set merge wrong");

	chk_rmw_clr: assert property (
		wr_clr |=> lat_ff == (($past(pin_lvl) & ~$past(reg_wdata_i[N-1:0])) & SIO_IMPL_MASK)
	) else $error("bit-clear merge wrong");

	// Data-out lands on the selected line one cycle after steering settles
	chk_sdo_line4: assert property (
		ser_out_en_i && sdo_line4 |=> pad_oe_o[4] && (pad_out_o[4] == $past(serial_data_out_i))
	) else $error("data-out not on line 4");

	chk_sdo_line0: assert property (
		ser_out_en_i && !sdo_line4 |=> pad_oe_o[0] && (pad_out_o[0] == $past(serial_data_out_i))
	) else $error("data-out not on line 0");

	// Deselected line of the pair keeps its port behaviour
	chk_sdo_unsel: assert property (
		ser_out_en_i && !sdo_line4 |=> pad_oe_o[4] == !$past(dir_ff[4])
	) else $error("deselected line disturbed");

	chk_ss_steer: assert property (
		1'h1 |=> ser_ss_n_o == ($past(steer_ff[1]) ? $past(pin_lvl[0]) : $past(pin_lvl[3]))
	) else $error("slave select mis-steered");

	chk_sdi_steer: assert property (
		1'h1 |=> serial_data_in_o == ($past(sda_line3) ? $past(pin_lvl[3]) : $past(pin_lvl[2]))
	) else $error("data-in mis-steered");

	chk_sda_low2: assert property (
		ser_sda_low_i && !sda_line3 |=> pad_oe_o[2] && !pad_out_o[2]
	) else $error("pull-low missing on line 2");

	chk_steer_read: assert property (
		reg_rd_i && (reg_addr_i == SIO_OFF_STEER) |=>
			reg_rdata_o[7] == 1'h0 && reg_rdata_o[3:0] == 4'h0
	) else $error("unused steering bits not zero");

	chk_steer_dir: assert property (
		wr_steer |=> dir_ff == $past(dir_ff)
	) else $error("steering changed direction");

	// A pin change reaches the read path after two synchroniser stages
	chk_sync_delay: assert property (
		$stable(pad_in_i) [*3] |-> pin_sync == pad_in_i
	) else $error("synchroniser latency wrong");

	// Only six lines exist; latch bits above them and on line 3 read zero
	chk_lat_absent: assert property (
		reg_rd_i && (reg_addr_i == SIO_OFF_LAT) |=> reg_rdata_o[7:6] == 2'h0 && !reg_rdata_o[3]
	) else $error("latch read shows absent bits");

	// Line 3 has no analog select, so its buffer is never switched off
	chk_ana_line3: assert property (
		ana_sel_o[3] == 1'h0
	) else $error("analog select on line 3");

	// A direction write reaches the driver enable after the pad flop
	chk_dir_write: assert property (
		wr_dir |=> ##1 pad_oe_o[5] == !$past(reg_wdata_i[5], 2)
	) else $error("direction write missed driver");

	// Main scenarios
	cov_dir_write: cover property (wr_dir ##1 (pad_oe_o != 6'h00));
	cov_rmw_clr: cover property (wr_clr ##1 (lat_ff != 6'h00));
	cov_pin_read: cover property (reg_rd_i && (reg_addr_i == SIO_OFF_PIN) && ana_ff == 6'h00);
	cov_steer_swap: cover property (wr_steer ##1 (sdo_line4 && ser_out_en_i));
	cov_line3_low: cover property (ser_sda_low_i && sda_line3 ##1 pad_oe_o[3]);
endmodule
`default_nettype wire

/* File: design/sio_sync.sv */
// Two-stage level synchroniser, parameterised width.
// Assumes inputs may change at any time relative to the clock.
`timescale 1ns/10ps
`default_nettype none
module sio_sync #(parameter int W = 6) (
	input wire logic sys_clk_i,     // System clock
	input wire logic sys_rst_i,     // Async reset, active high
	input wire logic [W-1:0] d_i,   // Raw level
	output logic [W-1:0] q_o        // Synchronised level
);
	logic [W-1:0] meta_ff;
	// First stage is read only by the second stage
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_ff <= '0;
			q_o <= '0;
		end else begin
			meta_ff <= d_i;
			q_o <= meta_ff;
		end
	end
endmodule
`default_nettype wire

/* File: pkg/sio_ovr_if.sv */
// Per-line drive request bundle between port control and the line driver cells.
// Assumes one control block as source and one driver cell per line as sink.
`timescale 1ns/10ps
`default_nettype none
interface sio_ovr_if #(parameter int N = 6);
	logic [N-1:0] gp_dat;  // Latch value
	logic [N-1:0] gp_oe;   // Driver enable from direction bits
	logic [N-1:0] ovr_en;  // Peripheral override active
	logic [N-1:0] ovr_dat; // Peripheral output level
	logic [N-1:0] ovr_oe;  // Peripheral driver enable
	wire logic [N-1:0] pad_dat; // Resolved pad level
	wire logic [N-1:0] pad_oe;  // Resolved pad enable
	modport ctl(output gp_dat, gp_oe, ovr_en, ovr_dat, ovr_oe, input pad_dat, pad_oe);
	modport drv(input gp_dat, gp_oe, ovr_en, ovr_dat, ovr_oe, output pad_dat, pad_oe);
endinterface
`default_nettype wire

/* File: pkg/sio_pkg.sv */
// Constants of the six-line I/O port: register offsets, reset values, field positions.
// Assumes a byte-wide register port with a 3-bit address, one clock and one reset.
// Operation
// - Six bidirectional lines with direction, latch, level
// - Direction bit 1 turns driver off
// - Direction bit 0 drives latch value out
// - Line 3 input-only, direction reads 1
// - Latch read stored; pin read live
// - Pin-level write updates latch like latch
// - Port writes are read-modify-write into latch (code: plain write on the port address; set/clear offsets merge pin levels)
// - Analog select disables digital input buffer
// - Analog lines read digital zero
// - Analog select leaves digital output alone
// - Direction controls driver even when analog
// - Analog select resets to analog mode
// - Peripheral owns output, level still readable
// - Steer bit 6: data-out line 4/0
// - Steer bit 5: slave-select line 0/3
// - Steer bit 4: data-in line 3/2
// - Steering leaves direction bits untouched
// - Unused steer bits read 0, reset 0
// - Highest priority enabled function owns line
package sio_pkg;
	localparam int SIO_ADDR_W = 3;
	// Register offsets, in register index units
	localparam logic [2:0] SIO_OFF_PIN = 3'h0;
	localparam logic [2:0] SIO_OFF_DIR = 3'h1;
	localparam logic [2:0] SIO_OFF_LAT = 3'h2;
	localparam logic [2:0] SIO_OFF_ANA = 3'h3;
	localparam logic [2:0] SIO_OFF_STEER = 3'h4;
	localparam logic [2:0] SIO_OFF_PIN_SET = 3'h5;
	localparam logic [2:0] SIO_OFF_PIN_CLR = 3'h6;
	// Lines that own latch, direction and analog bits (line 3 has none)
	localparam logic [5:0] SIO_IMPL_MASK = 6'h37;
	localparam logic [5:0] SIO_LINE3_MASK = 6'h08;
	localparam logic [5:0] SIO_DIR_RST = 6'h3F;
	localparam logic [5:0] SIO_ANA_RST = 6'h37;
	localparam logic [5:0] SIO_LAT_RST = 6'h00;
	localparam logic [2:0] SIO_STEER_RST = 3'h0;
	localparam logic SIO_SS_RST = 1'h1;
	// Steering field positions inside the steering register
	localparam int SIO_SDO_BIT = 6;
	localparam int SIO_SS_BIT = 5;
	localparam int SIO_SDI_BIT = 4;
	localparam int SIO_STEER_LSB = 4;
endpackage

/* File: tb/sio_pad_model.sv */
// Board-side model of the six pins: each pad shows the port's drive or the board's.
// Assumes the bench sets the board's drive level and the port drives pad_out/pad_oe.
`timescale 1ns/10ps
`default_nettype none
module sio_pad_model (
	input wire logic [5:0] pad_out_i, // Port drive level
	input wire logic [5:0] pad_oe_i,  // Port driver enable
	input wire logic [5:0] ext_val_i, // Board drive level
	output logic [5:0] pad_o          // Level seen on the pins
);
	// The port's driver wins over the weak board drive wherever it is enabled
	assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_val_i);
endmodule
`default_nettype wire

/* File: tb/sio_port_tb.sv */
// Self-checking bench for the six-line port: register reads go through a queue.
// Assumes the port answers reads one cycle after the strobe and never stalls.
`timescale 1ns/10ps
`default_nettype none
module sio_port_tb;
	import sio_pkg::*;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [2:0] reg_addr_i = 3'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic [5:0] pad_in_i, pad_out_o, pad_oe_o, ana_sel_o;
	logic [5:0] ext_val = 6'h00;
	logic ser_out_en_i = 1'b0;
	logic serial_data_out_i = 1'b0;
	logic ser_sda_low_i = 1'b0;
	logic serial_data_in_o, ser_ss_n_o, rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] lv, r;
	int num_errors = 0;
	int comparisons = 0;
	sio_port sio_port_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pad_in_i(pad_in_i),
		.pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .ana_sel_o(ana_sel_o),
		.ser_out_en_i(ser_out_en_i), .serial_data_out_i(serial_data_out_i),
		.ser_sda_low_i(ser_sda_low_i), .serial_data_in_o(serial_data_in_o),
		.ser_ss_n_o(ser_ss_n_o));
	sio_pad_model sio_pad_model_inst (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
		.ext_val_i(ext_val), .pad_o(pad_in_i));
	// 250 MHz clock
	initial begin
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One strobe cycle; the release edge keeps the strobes of back-to-back calls two cycles apart
	task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= w;
		reg_rd_i <= ~w;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		exp_q.push_back(exp);
		bus(1'b0, a, 8'h00);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe, so look there
	always @(posedge sys_clk_i) rd_seen <= reg_rd_i;
	always @(negedge sys_clk_i) begin
		if (rd_seen) begin
			cmp("read data", exp_q.pop_front(), reg_rdata_o);
		end
	end
	// Watchdog, far beyond the hundred or so cycles the tests need
	initial begin
		#20000;
		num_errors++;
		$display("watchdog expired");
		tally_and_finish();
	end
	initial begin
		void'($urandom(93198));
		tick(8);
		sys_rst_i <= 1'b0;
		rd(SIO_OFF_DIR, 8'h3F);
		rd(SIO_OFF_LAT, 8'h00);
		rd(SIO_OFF_ANA, 8'h37);
		rd(SIO_OFF_STEER, 8'h00);
		rd(3'h7, 8'h00);
		ext_val <= 6'h3F;
		tick(3);
		rd(SIO_OFF_PIN, 8'h08);
		cmp("analog select", 8'h37, {2'b00, ana_sel_o});
		$display("test reset done");
		// Software must leave analog mode before digital use
		bus(1'b1, SIO_OFF_ANA, 8'h00);
		bus(1'b1, SIO_OFF_STEER, 8'hFF);
		rd(SIO_OFF_STEER, 8'h70);
		bus(1'b1, SIO_OFF_STEER, 8'h00);
		bus(1'b1, SIO_OFF_DIR, 8'h00);
		rd(SIO_OFF_DIR, 8'h08);
		lv = 8'($urandom()) & 8'h37;
		bus(1'b1, SIO_OFF_LAT, lv);
		tick(2);
		@(negedge sys_clk_i);
		cmp("pad enable", 8'h37, {2'b00, pad_oe_o});
		cmp("pad drive", lv, {2'b00, pad_out_o & pad_oe_o});
		rd(SIO_OFF_PIN, lv | 8'h08);
		bus(1'b1, SIO_OFF_DIR, 8'h3F);
		ext_val <= ~lv[5:0];
		tick(3);
		rd(SIO_OFF_PIN, {2'b00, ~lv[5:0]});
		rd(SIO_OFF_LAT, lv);
		bus(1'b1, SIO_OFF_PIN, 8'h15);
		rd(SIO_OFF_LAT, 8'h15);
		bus(1'b1, SIO_OFF_PIN_SET, 8'h01);
		rd(SIO_OFF_LAT, ({2'b00, ~lv[5:0]} | 8'h01) & 8'h37);
		bus(1'b1, SIO_OFF_PIN_CLR, 8'h06);
		rd(SIO_OFF_LAT, {2'b00, ~lv[5:0]} & 8'h31);
		$display("test latch and pins done");
		// Analog lines with the driver on still drive their latch
		bus(1'b1, SIO_OFF_ANA, 8'h37);
		bus(1'b1, SIO_OFF_DIR, 8'h00);
		bus(1'b1, SIO_OFF_LAT, 8'h21);
		tick(2);
		@(negedge sys_clk_i);
		cmp("pad enable", 8'h37, {2'b00, pad_oe_o});
		cmp("pad drive", 8'h21, {2'b00, pad_out_o & pad_oe_o});
		rd(SIO_OFF_PIN, {4'h0, ~lv[3], 3'h0});
		bus(1'b1, SIO_OFF_DIR, 8'h3F);
		bus(1'b1, SIO_OFF_ANA, 8'h00);
		$display("test analog done");
		// Each steering choice in turn, for every function
		for (int s = 0; s < 2; s++) begin
			bus(1'b1, SIO_OFF_STEER, s[0] ? 8'h70 : 8'h00);
			r = 8'($urandom());
			ext_val <= r[5:0];
			ser_out_en_i <= 1'b1;
			serial_data_out_i <= r[7];
			tick(4);
			@(negedge sys_clk_i);
			cmp("serial out enable", s[0] ? 8'h10 : 8'h01, {2'b00, pad_oe_o});
			cmp("serial out level", {7'h00, r[7]}, {7'h00, pad_out_o[s[0] ? 4 : 0]});
			cmp("slave select", {7'h00, s[0] ? r[0] : r[3]}, {7'h00, ser_ss_n_o});
			cmp("serial in", {7'h00, s[0] ? r[3] : r[2]}, {7'h00, serial_data_in_o});
			rd(SIO_OFF_DIR, 8'h3F);
		end
		ser_out_en_i <= 1'b0;
		ser_sda_low_i <= 1'b1;
		tick(3);
		@(negedge sys_clk_i);
		cmp("data line pull", 8'h08, {2'b00, pad_oe_o});
		cmp("data line level", 8'h00, {4'h0, pad_out_o[3], 3'h0});
		$display("test steering done");
		tick(3);
		tally_and_finish();
	end
endmodule
`default_nettype wire
